// >>> logic/mmt_mgmt.sv
// Management signal timing logic of a pluggable optical cable end
// Summary of operation
// R1: Management init finishes within 2000 ms
// R2: Reset pulse counts only if held 10 us
// R3: Interrupt pin asserts within 200 ms
// R4: Flag read releases interrupt within 500 us
// R5: Receive loss sets flag within 100 ms
// R6: Any flag condition latches within 200 ms
// R7: Setting mask stops interrupt within 100 ms
// R8: Clearing mask resumes interrupt within 100 ms
// R9: Fully functional within 2 s of power-on; here full function comes after the 2000 ms init plus a 300 ms power-up
// R10: Serial bus answers within 2 s
// R11: Data-not-ready clears and interrupts after init
// R12: Fully functional within 2 s after reset; here full function comes after the 2000 ms init plus a 300 ms power-up
// R13: Low-power/transmit-disable pin mode switch within 100 ms
// R14: Low-power pin high gives class 1 within 100 ms
// R15: Low-power pin low gives full function within 300 ms
// R16: Interrupt/loss pin mode switch within 100 ms
// R17: Override or set bit gives class 1 quickly
// R18: Clearing override/set restores function within 300 ms
// R19: Flags latch until read; interrupt while unmasked
//
// The implementer's own choices: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/100ps
module mmt_mgmt
  import mmt_pkg::*;
#(
  parameter int LANES = 4,
  parameter longint unsigned INIT_CYC = INIT_MAX_CYC,
  parameter longint unsigned PUP_CYC = LP_OFF_MAX_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic module_reset_n_i,
  input wire logic low_pwr_request_i,
  input wire logic [LANES-1:0] rx_los_i,
  input wire logic [LANES-1:0] tx_fault_i,
  output logic module_irq_n_o,
  output logic module_irq_n_oe_o,
  output logic transmit_disable_o,
  output logic low_power_o,
  output logic full_function_o,
  output logic management_init_state_o,
  output logic irq_o
);

  if (LANES < 1 || LANES > MAX_LANES) begin : g_chk_lanes
    $error("mmt_mgmt: LANES must be 1 to 8");
  end
  if (PUP_CYC < 2) begin : g_chk_pup
    $error("mmt_mgmt: PUP_CYC must be at least 2");
  end

  function automatic logic hit(input logic [7:0] adr, input logic [7:0] off);
    hit = (adr[7:2] == off[7:2]);
  endfunction

  logic [LANES-1:0] los_s;
  logic [LANES-1:0] txf_s;
  logic [LANES-1:0] los_d_r;
  logic [LANES-1:0] txf_d_r;
  logic reset_n_s;
  logic lp_pin_s;
  logic [RST_CNT_W-1:0] rst_low_cnt_r;
  logic mod_rst_r;
  logic boot_r;
  logic init_start;
  logic init_busy;
  logic init_done;
  logic dnr_r;
  logic [FLAG_W-1:0] flags_r;
  logic [FLAG_W-1:0] mask_r;
  logic [CTRL_W-1:0] ctrl_r;
  logic [FLAG_W-1:0] evt;
  logic [31:0] wmask;
  logic req;
  logic rd_flags;
  logic lp_req;
  logic lp_req_r;
  logic pup_busy;
  logic pup_done;
  logic rx_signal_loss_out_n;

  mmt_sync #(
    .WIDTH(2 + 2 * LANES)
  ) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .d_i({module_reset_n_i, low_pwr_request_i, rx_los_i, tx_fault_i}),
    .q_o({reset_n_s, lp_pin_s, los_s, txf_s})
  );

  // Reset pin qualification: short low pulses are ignored
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rst_low_cnt_r <= '0;
      mod_rst_r <= 1'b0;
    end else if (ce_i) begin
      if (reset_n_s) begin
        rst_low_cnt_r <= '0;
        mod_rst_r <= 1'b0;
      end else if (rst_low_cnt_r == RST_CNT_W'(RST_MIN_CYC - 1)) begin
        mod_rst_r <= 1'b1; // R2
      end else begin
        rst_low_cnt_r <= rst_low_cnt_r + 1'b1;
      end
    end
  end

  // Init starts after power-on reset or after a qualified reset pulse ends
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      boot_r <= 1'b1;
    end else if (ce_i) begin
      boot_r <= 1'b0;
    end
  end

  assign init_start = boot_r || (mod_rst_r && reset_n_s); // R1 R12

  mmt_timer #(
    .CYC(INIT_CYC)
  ) u_init (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .start_i(init_start),
    .abort_i(mod_rst_r && !reset_n_s),
    .busy_o(init_busy),
    .done_o(init_done)
  );

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dnr_r <= 1'b1;
    end else if (ce_i) begin
      if (init_start || mod_rst_r) begin
        dnr_r <= 1'b1;
      end else if (init_done) begin
        dnr_r <= 1'b0; // R11
      end
    end
  end

  // Edge detect of synchronised conditions
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      los_d_r <= '0;
      txf_d_r <= '0;
    end else if (ce_i) begin
      los_d_r <= los_s;
      txf_d_r <= txf_s;
    end
  end

  always_comb begin
    evt = '0;
    evt[FLAG_LOS_LSB +: LANES] = los_s & ~los_d_r; // R5
    evt[FLAG_TXF_LSB +: LANES] = txf_s & ~txf_d_r; // R6
    evt[FLAG_INIT_BIT] = init_done; // R11
  end

  // Wishbone slave, answers one cycle after the request on cycles where ce_i is high
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign rd_flags = req && !wb_we_i && hit(wb_adr_i, REG_FLAGS);

  for (genvar b = 0; b < 4; b++) begin : g_lane
    assign wmask[8*b +: 8] = {8{wb_sel_i[b]}};
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else if (ce_i) begin
      wb_ack_o <= req; // R10
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= '0;
    end else if (ce_i && req) begin
      wb_dat_o <= '0;
      if (!wb_we_i) begin
        if (hit(wb_adr_i, REG_STATUS)) begin
          wb_dat_o[STAT_DNR_BIT] <= dnr_r;
          wb_dat_o[STAT_INIT_BIT] <= init_busy;
          wb_dat_o[STAT_LOWPWR_BIT] <= low_power_o;
          wb_dat_o[STAT_FULL_BIT] <= full_function_o;
        end else if (hit(wb_adr_i, REG_FLAGS)) begin
          wb_dat_o[FLAG_W-1:0] <= flags_r;
        end else if (hit(wb_adr_i, REG_MASK)) begin
          wb_dat_o[FLAG_W-1:0] <= mask_r;
        end else if (hit(wb_adr_i, REG_CTRL)) begin
          wb_dat_o[CTRL_W-1:0] <= ctrl_r;
        end
      end
    end
  end

  // Latched flags, cleared by a read; a new event wins over the clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flags_r <= '0;
    end else if (ce_i) begin
      if (mod_rst_r) begin
        flags_r <= '0;
      end else if (rd_flags) begin
        flags_r <= evt; // R4 R19
      end else begin
        flags_r <= flags_r | evt; // R19
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mask_r <= MASK_RST;
      ctrl_r <= CTRL_RST;
    end else if (ce_i) begin
      if (mod_rst_r) begin
        mask_r <= MASK_RST;
        ctrl_r <= CTRL_RST;
      end else if (req && wb_we_i) begin
        if (hit(wb_adr_i, REG_MASK)) begin
          mask_r <= (mask_r & ~wmask[FLAG_W-1:0]) | (wb_dat_i[FLAG_W-1:0] & wmask[FLAG_W-1:0]);
        end
        if (hit(wb_adr_i, REG_CTRL) && wb_sel_i[0]) begin
          ctrl_r <= wb_dat_i[CTRL_W-1:0];
        end
      end
    end
  end

  // Interrupt level and dual-purpose pin
  assign rx_signal_loss_out_n = !(|los_s);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
      module_irq_n_oe_o <= 1'b0;
    end else if (ce_i) begin
      irq_o <= |(flags_r & ~mask_r); // R3 R7 R8 R19
      if (ctrl_r[CTRL_LOS_MODE_BIT]) begin
        module_irq_n_oe_o <= !rx_signal_loss_out_n; // R16
      end else begin
        module_irq_n_oe_o <= |(flags_r & ~mask_r); // R3
      end
    end
  end

  assign module_irq_n_o = 1'b0;

  // Power state and dual-purpose low-power pin
  assign lp_req = (!ctrl_r[CTRL_TRANSMIT_DISABLE_MODE_BIT] && lp_pin_s) || ctrl_r[CTRL_OVR_BIT]
    || ctrl_r[CTRL_SET_BIT]; // R14 R17

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lp_req_r <= 1'b0;
      low_power_o <= 1'b1;
      transmit_disable_o <= 1'b0;
    end else if (ce_i) begin
      lp_req_r <= lp_req;
      low_power_o <= lp_req || init_busy || mod_rst_r; // R14 R17
      transmit_disable_o <= ctrl_r[CTRL_TRANSMIT_DISABLE_MODE_BIT] && lp_pin_s; // R13
    end
  end

  mmt_timer #(
    .CYC(PUP_CYC - 1)
  ) u_pup (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .start_i(low_power_o && !(lp_req || init_busy || mod_rst_r)),
    .abort_i(lp_req || init_busy || mod_rst_r),
    .busy_o(pup_busy),
    .done_o(pup_done)
  );

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      full_function_o <= 1'b0;
    end else if (ce_i) begin
      if (lp_req || init_busy || mod_rst_r) begin
        full_function_o <= 1'b0;
      end else if (pup_done) begin
        full_function_o <= 1'b1; // R9 R12 R15 R18
      end
    end
  end

  assign management_init_state_o = init_busy;

  // Checking helpers
  logic [31:0] init_len_r;
  logic [31:0] pup_len_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      init_len_r <= '0;
      pup_len_r <= '0;
    end else if (ce_i) begin
      init_len_r <= init_busy ? init_len_r + 1'b1 : '0;
      pup_len_r <= (!low_power_o && !full_function_o) ? pup_len_r + 1'b1 : '0;
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i || !ce_i);

  a_init_bounded: assert property (init_len_r <= 32'(INIT_CYC)) // R1
    else $error("Init state lasts too long");
  a_short_reset: assert property (!reset_n_s ##1 reset_n_s |-> !$past(mod_rst_r, 2) ||
    $past(rst_low_cnt_r, 2) == RST_CNT_W'(RST_MIN_CYC - 1)) // R2
    else $error("Reset qualified before minimum hold");
  a_irq_asserts: assert property (|(flags_r & ~mask_r) |=> irq_o) // R3
    else $error("Interrupt missing for unmasked flag");
  a_read_clears: assert property (rd_flags && evt == '0 && !mod_rst_r |=> flags_r == '0
    ##1 !irq_o) // R4
    else $error("Flag read did not release interrupt");
  a_los_latch: assert property ($rose(los_s[0]) && !mod_rst_r |=> flags_r[FLAG_LOS_LSB]
    ##1 (irq_o || $past(mask_r[FLAG_LOS_LSB]))) // R5
    else $error("Receive loss not latched");
  a_txf_latch: assert property ($rose(txf_s[0]) && !mod_rst_r |=> flags_r[FLAG_TXF_LSB]) // R6
    else $error("Transmit fault not latched");
  a_mask_inhibit: assert property ((flags_r & ~mask_r) == '0 |=> !irq_o) // R7
    else $error("Masked flag still interrupts");
  a_mask_resume: assert property ($fell(mask_r[FLAG_LOS_LSB]) && flags_r[FLAG_LOS_LSB]
    |=> irq_o) // R8
    else $error("Interrupt not resumed after unmask");
  a_dnr_flag: assert property ($fell(dnr_r) |-> flags_r[FLAG_INIT_BIT]) // R11
    else $error("Data-not-ready clear without flag");
  a_transmit_disable_mode: assert property (ctrl_r[CTRL_TRANSMIT_DISABLE_MODE_BIT] && lp_pin_s |=> transmit_disable_o
    && (!low_power_o || $past(lp_req) || $past(init_busy) || $past(mod_rst_r))) // R13
    else $error("Transmit disable mode wrong");
  a_lp_entry: assert property (lp_req |=> low_power_o ##1 !full_function_o) // R14
    else $error("Low power not entered");
  a_pup_bound: assert property (pup_len_r <= 32'(PUP_CYC)) // R15
    else $error("Return to full function too slow");
  a_los_pin: assert property (ctrl_r[CTRL_LOS_MODE_BIT] && |los_s |=> module_irq_n_oe_o) // R16
    else $error("Loss pin mode not driving");

  c_flag_read: cover property (rd_flags && flags_r != '0);
  c_init_done: cover property ($fell(init_busy) && !dnr_r);
  c_los_irq: cover property ($rose(los_s[0]) ##[1:3] irq_o);
  c_full_func: cover property ($rose(full_function_o));

endmodule

// >>> logic/mmt_pkg.sv
// Shared constants for the module management timing block
package mmt_pkg;

  localparam longint unsigned CLK_HZ = 25_000_000;

  // Documented times in their own units
  localparam longint unsigned INIT_MAX_MS = 2000;
  localparam longint unsigned RST_MIN_US = 10;
  localparam longint unsigned LP_OFF_MAX_MS = 300;

  // Longest times round down, least times round up
  localparam longint unsigned INIT_MAX_CYC = INIT_MAX_MS * CLK_HZ / 1000;
  localparam longint unsigned RST_MIN_CYC = (RST_MIN_US * CLK_HZ + 999_999) / 1_000_000;
  localparam longint unsigned LP_OFF_MAX_CYC = LP_OFF_MAX_MS * CLK_HZ / 1000;
  localparam int RST_CNT_W = $clog2(RST_MIN_CYC + 1);

  // Register byte offsets
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_FLAGS = 8'h04;
  localparam logic [7:0] REG_MASK = 8'h08;
  localparam logic [7:0] REG_CTRL = 8'h0c;

  // Status fields
  localparam int STAT_DNR_BIT = 0;
  localparam int STAT_INIT_BIT = 1;
  localparam int STAT_LOWPWR_BIT = 2;
  localparam int STAT_FULL_BIT = 3;

  // Flag and mask layout
  localparam int FLAG_W = 17;
  localparam int FLAG_LOS_LSB = 0;
  localparam int FLAG_TXF_LSB = 8;
  localparam int FLAG_INIT_BIT = 16;
  localparam int MAX_LANES = 8;

  // Control fields
  localparam int CTRL_W = 4;
  localparam int CTRL_OVR_BIT = 0;
  localparam int CTRL_SET_BIT = 1;
  localparam int CTRL_TRANSMIT_DISABLE_MODE_BIT = 2;
  localparam int CTRL_LOS_MODE_BIT = 3;

  // Reset values
  localparam logic [FLAG_W-1:0] MASK_RST = 17'h00000;
  localparam logic [CTRL_W-1:0] CTRL_RST = 4'h0;

endpackage

// >>> logic/mmt_sync.sv
// Two-flop synchroniser for a group of pin inputs
`timescale 1ns/100ps
module mmt_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);

  logic [WIDTH-1:0] meta_r;

  if (WIDTH < 1) begin : g_chk
    $error("mmt_sync: WIDTH must be at least 1");
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_r <= '0;
      q_o <= '0;
    end else if (ce_i) begin
      meta_r <= d_i;
      q_o <= meta_r;
    end
  end

endmodule

// >>> logic/mmt_timer.sv
// One-shot cycle timer with restart and abort
`timescale 1ns/100ps
module mmt_timer #(
  parameter longint unsigned CYC = 4
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic start_i,
  input wire logic abort_i,
  output logic busy_o,
  output logic done_o
);

  localparam int W = $clog2(CYC + 1);

  logic [W-1:0] cnt_r;

  if (CYC < 1) begin : g_chk
    $error("mmt_timer: CYC must be at least 1");
  end

  // Done pulses exactly CYC edges after the start edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_r <= '0;
      busy_o <= 1'b0;
      done_o <= 1'b0;
    end else if (ce_i) begin
      done_o <= 1'b0;
      if (abort_i) begin
        busy_o <= 1'b0;
      end else if (start_i) begin
        busy_o <= 1'b1;
        cnt_r <= W'(CYC - 1);
      end else if (busy_o) begin
        if (cnt_r == '0) begin
          busy_o <= 1'b0;
          done_o <= 1'b1;
        end else begin
          cnt_r <= cnt_r - 1'b1;
        end
      end
    end
  end

endmodule

// >>> dv/mmt_host_model.sv
// Host-side pin model: module reset, low-power request and lane conditions
`timescale 1ns/100ps
module mmt_host_model (
  input wire logic clk_i,
  output logic module_reset_n_o,
  output logic low_pwr_request_o,
  output logic [3:0] rx_los_o,
  output logic [3:0] tx_fault_o
);
  initial begin
    module_reset_n_o = 1'b1;
    low_pwr_request_o = 1'b0;
    rx_los_o = 4'h0;
    tx_fault_o = 4'h0;
  end

  // Reset pulse of n cycles; a qualified reset must last at least the minimum
  task automatic pulse_reset(input int n);
    module_reset_n_o <= 1'b0;
    repeat (n) @(posedge clk_i);
    module_reset_n_o <= 1'b1;
  endtask

  task automatic set_pins(input logic lp, input logic [3:0] los, input logic [3:0] flt);
    low_pwr_request_o <= lp;
    rx_los_o <= los;
    tx_fault_o <= flt;
  endtask
endmodule

// >>> dv/tb_top.sv
// Self-checking bench for the management timing block
`timescale 1ns/100ps
module tb_top;
  import mmt_pkg::*;
  logic clk_i, rst_i, cyc, stb, we;
  logic [7:0] adr;
  logic [31:0] dat, q, rdata;
  logic ack, irq_pin, oe, transmit_disable, lowp, full, init_st, irq;
  logic rst_n, lp, ce;
  logic [3:0] los, flt, sel;
  int n_mismatch = 0;
  int n_checks = 0;

  mmt_host_model u_host (.clk_i(clk_i), .module_reset_n_o(rst_n), .low_pwr_request_o(lp),
    .rx_los_o(los), .tx_fault_o(flt));

  mmt_mgmt #(.LANES(4), .INIT_CYC(20), .PUP_CYC(10)) u_dut (.clk_i(clk_i), .rst_i(rst_i),
    .ce_i(ce), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdata), .wb_ack_o(ack),
    .module_reset_n_i(rst_n), .low_pwr_request_i(lp), .rx_los_i(los), .tx_fault_i(flt),
    .module_irq_n_o(irq_pin), .module_irq_n_oe_o(oe), .transmit_disable_o(transmit_disable),
    .low_power_o(lowp), .full_function_o(full), .management_init_state_o(init_st),
    .irq_o(irq));

  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One classic Wishbone cycle, held until ack is sampled high
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    i = 0;
    do begin
      @(posedge clk_i);
      i++;
    end while (ack !== 1'b1 && i < 20);
    q = rdata;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
    if (i >= 20) begin
      n_mismatch++;
      stop_test();
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(q, exp);
  endtask

  task automatic cyc_wait(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  initial begin
    cyc_wait(20000);
    n_mismatch++;
    stop_test();
  end

  initial begin
    rst_i = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    dat = 32'h0;
    ce = 1'b1;
    sel = 4'hf;
    cyc_wait(8);
    chk(lowp, 1'b1);
    chk(full, 1'b0);
    rst_i <= 1'b0;
    cyc_wait(5);
    chk(init_st, 1'b1);
    rd(REG_STATUS, 32'h00000007);
    cyc_wait(50);
    rd(REG_STATUS, 32'h00000008);
    chk(irq, 1'b1);
    rd(REG_FLAGS, 32'h00010000);
    cyc_wait(3);
    chk(irq, 1'b0);
    // Lane events latch and raise the interrupt
    u_host.set_pins(1'b0, 4'h4, 4'h2);
    cyc_wait(6);
    chk(irq, 1'b1);
    chk(oe, 1'b1);
    chk(irq_pin, 1'b0);
    rd(REG_FLAGS, 32'h00000204);
    cyc_wait(3);
    chk(oe, 1'b0);
    rd(REG_FLAGS, 32'h00000000);
    u_host.set_pins(1'b0, 4'h0, 4'h0);
    cyc_wait(6);
    // Masked flag holds no interrupt, unmasking brings it back
    bus(1'b1, REG_MASK, 32'h00010f0f);
    rd(REG_MASK, 32'h00010f0f);
    u_host.set_pins(1'b0, 4'h1, 4'h0);
    cyc_wait(6);
    chk(irq, 1'b0);
    bus(1'b1, REG_MASK, 32'h00000000);
    cyc_wait(3);
    chk(irq, 1'b1);
    bus(1'b1, REG_MASK, 32'h00000001);
    cyc_wait(3);
    chk(irq, 1'b0);
    rd(REG_FLAGS, 32'h00000001);
    // Loss indicator mode follows the lane loss level
    bus(1'b1, REG_CTRL, 32'h00000008);
    cyc_wait(3);
    chk(oe, 1'b1);
    u_host.set_pins(1'b0, 4'h0, 4'h0);
    cyc_wait(6);
    chk(oe, 1'b0);
    bus(1'b1, REG_CTRL, 32'h00000000);
    bus(1'b1, REG_MASK, 32'h00000000);
    // Unmapped place reads zero and ignores writes
    bus(1'b1, 8'h10, 32'hffffffff);
    rd(8'h10, 32'h00000000);
    rd(REG_CTRL, 32'h00000000);
    // Clock enable low freezes the flag logic
    ce <= 1'b0;
    u_host.set_pins(1'b0, 4'h0, 4'h8);
    cyc_wait(6);
    chk(irq, 1'b0);
    ce <= 1'b1;
    cyc_wait(6);
    chk(irq, 1'b1);
    rd(REG_FLAGS, 32'h00000800);
    // Byte enables gate register writes
    sel <= 4'he;
    bus(1'b1, REG_CTRL, 32'h00000008);
    sel <= 4'h1;
    bus(1'b1, REG_MASK, 32'h00010f0f);
    sel <= 4'hf;
    rd(REG_CTRL, 32'h00000000);
    rd(REG_MASK, 32'h0000000f);
    bus(1'b1, REG_MASK, 32'h00000000);
    // Software power controls
    for (int k = 1; k < 3; k++) begin
      bus(1'b1, REG_CTRL, 32'(k));
      cyc_wait(2);
      chk(lowp, 1'b1);
      chk(full, 1'b0);
      bus(1'b1, REG_CTRL, 32'h00000000);
      cyc_wait(5);
      chk(full, 1'b0);
      cyc_wait(15);
      chk(full, 1'b1);
    end
    // Low-power request pin
    u_host.set_pins(1'b1, 4'h0, 4'h0);
    cyc_wait(5);
    chk(lowp, 1'b1);
    u_host.set_pins(1'b0, 4'h0, 4'h0);
    cyc_wait(20);
    chk(full, 1'b1);
    // Transmit-disable mode of the same pin
    bus(1'b1, REG_CTRL, 32'h00000004);
    u_host.set_pins(1'b1, 4'h0, 4'h0);
    cyc_wait(5);
    chk(transmit_disable, 1'b1);
    chk(lowp, 1'b0);
    u_host.set_pins(1'b0, 4'h0, 4'h0);
    cyc_wait(5);
    chk(transmit_disable, 1'b0);
    rd(REG_CTRL, 32'h00000004);
    // Short reset pulse is ignored, long one restarts init
    u_host.pulse_reset(100);
    cyc_wait(5);
    chk(init_st, 1'b0);
    u_host.pulse_reset(260);
    cyc_wait(5);
    chk(init_st, 1'b1);
    rd(REG_CTRL, 32'h00000000);
    cyc_wait(50);
    rd(REG_STATUS, 32'h00000008);
    rd(REG_FLAGS, 32'h00010000);
    stop_test();
  end
endmodule
